//--- pcs_consts.svh
// Register indices, field positions, reset values and times of the block.
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH
`define IDX_CS0_BASE  8'h4a
`define IDX_CS0_CTRL  8'h4b
`define IDX_CS1_BASE  8'h4c
`define IDX_CS1_CTRL  8'h4d
`define IDX_LATCH     8'h54
`define IDX_PIN_DATA  8'h56
`define IDX_PIN_DIR   8'h57
`define IDX_PIN_FUNC  8'h66
`define IDX_RECOVERY  8'h68
`define IDX_FEATURE   8'ha0
`define IDX_CS_HIGH   8'ha7
`define IDX_CS_TYPE   8'hb3
`define IDX_CS2_BASE  8'hba
`define IDX_CS2_CTRL  8'hbb
`define IDX_CS3_BASE  8'hbc
`define IDX_CS3_CTRL  8'hbd
`define IDX_OVERRIDE  8'hbe
`define IDX_CS_GRAN   8'hbf
`define CTRL_A_HI     7
`define CTRL_WR_EN    6
`define CTRL_RD_EN    5
`define GRAN_BASE_LO  4
`define FUNC_STOP_GRANT_ACK   3
`define FUNC_CPU_FULL_SPEED_FLAG   2
`define FUNC_ZERO_WAIT_REQUEST     1
`define FEAT_LBM      5
`define HIGH_IGNORE   7
`define OVR_BIT       0
`define REC_SEL_HI    3
`define REC_SEL_LO    2
`define REG_RESET     8'h00
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`define CS0_LINE      2
`define CS1_LINE      3
`define CS2_LINE      0
`define CS3_LINE      1
`define CLK_HZ        10000000
`define T_8_MS        8
`define T_32_MS       32
`define T_128_MS      128
`define T_30_US       30
`define T_1_S         1
`endif

//--- pcs_far_side.sv
// Far-side model: AT bus master and board pull-ups on the general pins.
`timescale 1ns/10ps
module pcs_far_side
  import pcs_pkg::*;
(
  input  wire logic [3:0] general_pins_out,
  input  wire logic [3:0] general_pins_oe,
  input  wire logic [3:0] pins_pull_low,
  input  wire logic       core_clk,
  output logic [3:0]      general_pins_in,
  output logic            at_cycle_strobe_n,
  output pcs_at_cycle_s   at_cycle
);
  // An undriven pin rests high on its pull-up unless the board holds it low.
  // never floats
  assign general_pins_in = (general_pins_oe & general_pins_out) |
                           (~general_pins_oe & ~pins_pull_low);
  // The bus starts idle.
  initial
  begin
    at_cycle_strobe_n = 1'b1;
    at_cycle = '1;
  end
  // strobe qualifies address
  // The address holds for the whole strobe and drifts once it is released.
  task automatic start(input pcs_at_cycle_s c);
    @(posedge core_clk);
    at_cycle <= c;
    at_cycle_strobe_n <= 1'b0;
  endtask : start
  task automatic stop;
    @(posedge core_clk);
    at_cycle_strobe_n <= 1'b1;
    at_cycle <= ~at_cycle;
  endtask : stop
endmodule : pcs_far_side

//--- pcs_pkg.sv
// Types shared by the chip select, pin and resume block.
package pcs_pkg;
  typedef logic [7:0] pcs_byte_t;
  typedef struct packed {
    logic [23:0] addr;
    logic        io;
    logic        rd;
    logic        wr;
  } pcs_at_cycle_s;
  typedef enum logic [1:0] {PWR_RUN, PWR_SUSP, PWR_REC} pcs_pwr_e;
endpackage : pcs_pkg

//--- pcs_top.sv
// Resume recovery, power line auto toggle, general pins and chip selects.
`timescale 1ns/10ps
`include "pcs_consts.svh"
module pcs_top
  import pcs_pkg::*;
#(
  parameter int unsigned REC_8MS_CYC   = `T_8_MS * (`CLK_HZ / 1000),
  parameter int unsigned REC_32MS_CYC  = `T_32_MS * (`CLK_HZ / 1000),
  parameter int unsigned REC_128MS_CYC = `T_128_MS * (`CLK_HZ / 1000),
  parameter int unsigned REC_1S_CYC    = `T_1_S * `CLK_HZ
)
(
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  input  wire logic [11:0]   s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [11:0]   s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          suspend_active,
  input  wire logic          at_cycle_strobe_n,
  input  wire pcs_at_cycle_s at_cycle,
  output logic [3:0]         cs_ma_lines,
  output logic [3:0]         power_latch_lines_low,
  output logic               peripheral_resume_reset_n,
  output logic               secondary_reset_out_n,
  output logic               clock_run,
  input  wire logic [3:0]    general_pins_in,
  output logic [3:0]         general_pins_out,
  output logic [3:0]         general_pins_oe,
  input  wire logic          cpu_full_speed_flag,
  output logic               stop_grant_ack,
  output logic               zero_wait_active,
  input  wire logic          dma_ack_channel_two_n,
  output logic               dma_ack_pin_n
);
  localparam int unsigned REC_30US_CYC = `T_30_US * `CLK_HZ / 1000000;
  localparam int CS_LINE [4] = '{`CS0_LINE, `CS1_LINE, `CS2_LINE, `CS3_LINE};

  // Index is the printed register offset; byte address is four times it.
  function automatic logic pcs_mapped(input pcs_byte_t idx);
    case (idx)
      `IDX_CS0_BASE, `IDX_CS0_CTRL, `IDX_CS1_BASE, `IDX_CS1_CTRL,
      `IDX_LATCH, `IDX_PIN_DATA, `IDX_PIN_DIR, `IDX_PIN_FUNC,
      `IDX_RECOVERY, `IDX_FEATURE, `IDX_CS_HIGH, `IDX_CS_TYPE,
      `IDX_CS2_BASE, `IDX_CS2_CTRL, `IDX_CS3_BASE, `IDX_CS3_CTRL,
      `IDX_OVERRIDE, `IDX_CS_GRAN: pcs_mapped = 1'b1;
      default: pcs_mapped = 1'b0;
    endcase
  endfunction : pcs_mapped

  pcs_byte_t cs_base [4];
  pcs_byte_t cs_ctrl [4];
  pcs_byte_t cs_cycle_type;
  pcs_byte_t cs_granular;
  pcs_byte_t cs_high_cfg;
  pcs_byte_t pin_direction;
  pcs_byte_t pin_function_select;
  pcs_byte_t feature_control_one;
  pcs_byte_t recovery_cfg;
  pcs_byte_t override_cfg;
  logic [3:0]  pin_data;
  logic [3:0]  latch_data;
  logic        aw_got;
  logic        w_got;
  pcs_byte_t   aw_idx;
  logic [31:0] wdata_q;
  logic        wstrb_q;
  logic        wr_go;
  pcs_byte_t   ar_idx;
  pcs_byte_t   next_rdata;
  logic [3:0]  pin_s1;
  logic [3:0]  pin_s2;
  logic [3:0]  pin_s3;
  logic [3:0]  pin_level;
  pcs_pwr_e    pwr_state;
  logic [23:0] rec_cnt;
  logic [23:0] next_rec_load;
  logic [3:0]  next_cs_hit;
  logic        lbm_on;

  assign wr_go  = aw_got & w_got & ~s_axi_bvalid;
  assign ar_idx = s_axi_araddr[9:2];
  assign lbm_on = feature_control_one[`FEAT_LBM];

  // Write channels are taken in either order; the answer follows both.
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_idx        <= `REG_RESET;
      wdata_q       <= '0;
      wstrb_q       <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got        <= 1'b1;
        aw_idx        <= s_axi_awaddr[9:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got        <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= pcs_mapped(aw_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end

  // Register writes; only byte lane 0 carries data, upper lanes are ignored.
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      for (int i = 0; i < 4; i++)
      begin
        cs_base[i] <= `REG_RESET;
        cs_ctrl[i] <= `REG_RESET;
      end
      cs_cycle_type       <= `REG_RESET;
      cs_granular         <= `REG_RESET;
      cs_high_cfg         <= `REG_RESET;
      pin_direction       <= `REG_RESET;
      pin_function_select <= `REG_RESET;
      feature_control_one <= `REG_RESET;
      recovery_cfg        <= `REG_RESET;
      override_cfg        <= `REG_RESET;
      pin_data            <= '0;
      latch_data          <= '0;
    end
    else if (wr_go && wstrb_q)
    begin
      case (aw_idx)
        `IDX_CS0_BASE: cs_base[0] <= wdata_q[7:0];
        `IDX_CS0_CTRL: cs_ctrl[0] <= wdata_q[7:0];
        `IDX_CS1_BASE: cs_base[1] <= wdata_q[7:0];
        `IDX_CS1_CTRL: cs_ctrl[1] <= wdata_q[7:0];
        `IDX_CS2_BASE: cs_base[2] <= wdata_q[7:0];
        `IDX_CS2_CTRL: cs_ctrl[2] <= wdata_q[7:0];
        `IDX_CS3_BASE: cs_base[3] <= wdata_q[7:0];
        `IDX_CS3_CTRL: cs_ctrl[3] <= wdata_q[7:0];
        `IDX_CS_TYPE:  cs_cycle_type <= wdata_q[7:0];
        `IDX_CS_GRAN:  cs_granular <= wdata_q[7:0];
        `IDX_CS_HIGH:  cs_high_cfg <= wdata_q[7:0];
        `IDX_PIN_DIR:  pin_direction <= wdata_q[7:0];
        `IDX_PIN_FUNC: pin_function_select <= wdata_q[7:0];
        `IDX_FEATURE:  feature_control_one <= wdata_q[7:0];
        `IDX_RECOVERY: recovery_cfg <= wdata_q[7:0];
        `IDX_OVERRIDE: override_cfg <= wdata_q[7:0];
        `IDX_LATCH:
          for (int j = 0; j < 4; j++)
            if (wdata_q[4+j])
              latch_data[j] <= wdata_q[j];
        `IDX_PIN_DATA:
          for (int j = 0; j < 4; j++)
            if (wdata_q[4+j])
              pin_data[j] <= wdata_q[j];
        default: ;
      endcase
    end

  // Read mux; the pin register shows the pin level for input pins.
  always_comb
    case (ar_idx)
      `IDX_CS0_BASE: next_rdata = cs_base[0];
      `IDX_CS0_CTRL: next_rdata = cs_ctrl[0];
      `IDX_CS1_BASE: next_rdata = cs_base[1];
      `IDX_CS1_CTRL: next_rdata = cs_ctrl[1];
      `IDX_CS2_BASE: next_rdata = cs_base[2];
      `IDX_CS2_CTRL: next_rdata = cs_ctrl[2];
      `IDX_CS3_BASE: next_rdata = cs_base[3];
      `IDX_CS3_CTRL: next_rdata = cs_ctrl[3];
      `IDX_CS_TYPE:  next_rdata = cs_cycle_type;
      `IDX_CS_GRAN:  next_rdata = cs_granular;
      `IDX_CS_HIGH:  next_rdata = cs_high_cfg;
      `IDX_PIN_DIR:  next_rdata = pin_direction;
      `IDX_PIN_FUNC: next_rdata = pin_function_select;
      `IDX_FEATURE:  next_rdata = feature_control_one;
      `IDX_RECOVERY: next_rdata = recovery_cfg;
      `IDX_OVERRIDE: next_rdata = override_cfg;
      `IDX_LATCH:    next_rdata = {4'h0, latch_data};
      `IDX_PIN_DATA:
        next_rdata = {4'h0, (pin_data & pin_direction[3:0])
                            | (pin_level & ~pin_direction[3:0])};
      default:       next_rdata = `REG_RESET;
    endcase

  // Read answer one cycle after the address is taken.
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, next_rdata};
      s_axi_rresp   <= pcs_mapped(ar_idx) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end

  // Recovery length; the override wins so firmware can force a safe 1 s.
  always_comb
  begin
    case (recovery_cfg[`REC_SEL_HI:`REC_SEL_LO])
      2'h0:    next_rec_load = 24'(REC_8MS_CYC - 1);
      2'h1:    next_rec_load = 24'(REC_32MS_CYC - 1);
      2'h2:    next_rec_load = 24'(REC_128MS_CYC - 1);
      default: next_rec_load = 24'(REC_30US_CYC - 1);
    endcase
    if (override_cfg[`OVR_BIT])
      next_rec_load = 24'(REC_1S_CYC - 1);
  end

  // Suspend and resume sequence with the recovery counter.
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      pwr_state <= PWR_RUN;
      rec_cnt   <= '0;
    end
    else
      case (pwr_state)
        PWR_RUN:
          if (suspend_active)
            pwr_state <= PWR_SUSP;
        PWR_SUSP:
          if (!suspend_active)
          begin
            pwr_state <= PWR_REC;
            rec_cnt   <= next_rec_load;
          end
        PWR_REC:
          if (rec_cnt == '0)
            pwr_state <= PWR_RUN;
          else
            rec_cnt <= rec_cnt - 24'h000001;
        default: pwr_state <= PWR_RUN;
      endcase

  // Reset and clock request outputs; the clock stays on across recovery.
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      peripheral_resume_reset_n <= 1'b0;
      secondary_reset_out_n     <= 1'b0;
      clock_run                 <= 1'b1;
    end
    else
    begin
      peripheral_resume_reset_n <= !(pwr_state == PWR_REC);
      secondary_reset_out_n     <= !(pwr_state == PWR_REC);
      clock_run <= (pwr_state != PWR_SUSP) || !suspend_active;
    end

  // Power latch lines; lines 0 and 1 toggle in suspend when enabled.
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
      power_latch_lines_low <= '0;
    else
    begin
      power_latch_lines_low[3:2] <= latch_data[3:2];
      for (int k = 0; k < 2; k++)
        power_latch_lines_low[k] <=
          (pwr_state == PWR_SUSP && recovery_cfg[k]) ? ~latch_data[k]
                                                     : latch_data[k];
    end

  // Pin inputs come from the board; a change counts when stages 2 and 3 agree.
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      pin_s1    <= '1;
      pin_s2    <= '1;
      pin_s3    <= '1;
      pin_level <= '1;
    end
    else
    begin
      pin_s1 <= general_pins_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (int j = 0; j < 4; j++)
        if (pin_s2[j] == pin_s3[j])
          pin_level[j] <= pin_s3[j];
    end

  // Pin drivers and the special functions routed through them.
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      general_pins_out <= '0;
      general_pins_oe  <= '0;
      stop_grant_ack   <= 1'b0;
      zero_wait_active <= 1'b0;
      dma_ack_pin_n    <= 1'b1;
    end
    else
    begin
      general_pins_oe <= pin_direction[3:0] & {3'h7, ~lbm_on};
      general_pins_out <= pin_data;
      if (pin_function_select[`FUNC_CPU_FULL_SPEED_FLAG])
        general_pins_out[2] <= cpu_full_speed_flag;
      stop_grant_ack <= pin_function_select[`FUNC_STOP_GRANT_ACK] & ~pin_level[3];
      zero_wait_active <= pin_function_select[`FUNC_ZERO_WAIT_REQUEST] & ~pin_level[1]
                          & ~at_cycle_strobe_n;
      // grant on the DMA ack pin
      dma_ack_pin_n <= lbm_on ? ~(~pin_level[0] & at_cycle_strobe_n)
                              : dma_ack_channel_two_n;
    end

  // Chip select compare; I/O uses A[9:0], memory uses A[23:14].
  // four independent selects
  for (genvar i = 0; i < 4; i++)
  begin : g_cs
    logic [9:0] want;
    logic [9:0] msk;
    logic [9:0] addr;
    logic       kind_ok;
    logic       high_ok;
    assign want = {cs_ctrl[i][`CTRL_A_HI], cs_base[i],
                   cs_granular[`GRAN_BASE_LO+i]};
    assign msk  = {5'h00, cs_ctrl[i][3:0], cs_granular[i]};
    assign addr = at_cycle.io ? at_cycle.addr[9:0] : at_cycle.addr[23:14];
    assign kind_ok = at_cycle.io ^ cs_cycle_type[i];
    assign high_ok = !at_cycle.io || cs_high_cfg[`HIGH_IGNORE]
                     || (at_cycle.addr[15:10] == 6'h00);
    assign next_cs_hit[i] = !at_cycle_strobe_n && kind_ok && high_ok
                            && (((addr ^ want) & ~msk) == 10'h000)
                            && ((at_cycle.rd && cs_ctrl[i][`CTRL_RD_EN])
                             || (at_cycle.wr && cs_ctrl[i][`CTRL_WR_EN]));
  end

  // Selects leave the chip on spare address lines, low when selected.
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
      cs_ma_lines <= '1;
    else
      for (int i = 0; i < 4; i++)
        cs_ma_lines[CS_LINE[i]] <= ~next_cs_hit[i];

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_reset_in_recovery: assert property (
    $past(pwr_state) == PWR_REC |-> !peripheral_resume_reset_n
                                    && !secondary_reset_out_n)
    else $error("Resume reset released during recovery.");
  a_clock_in_recovery: assert property (
    pwr_state == PWR_REC ##1 pwr_state == PWR_REC |-> clock_run)
    else $error("Clock stopped during recovery.");
  a_override_one_sec: assert property (
    pwr_state == PWR_SUSP && !suspend_active && override_cfg[0]
    |=> rec_cnt == 24'(REC_1S_CYC - 1))
    else $error("Override did not load one second.");
  a_short_recovery: assert property (
    pwr_state == PWR_SUSP && !suspend_active && !override_cfg[0]
    && recovery_cfg[3:2] == 2'h3 |=> rec_cnt == 24'(REC_30US_CYC - 1))
    else $error("Code 11 did not load 30 us.");
  a_toggle_in_suspend: assert property (
    pwr_state == PWR_SUSP && recovery_cfg[0]
    |=> power_latch_lines_low[0] == ~$past(latch_data[0]))
    else $error("Line 0 not inverted in suspend.");
  a_restore_on_resume: assert property (
    pwr_state == PWR_REC ##1 pwr_state == PWR_REC
    |-> power_latch_lines_low[1:0] == $past(latch_data[1:0]))
    else $error("Lines not restored during recovery.");
  a_cs_needs_cycle: assert property (
    at_cycle_strobe_n |=> cs_ma_lines == 4'hf)
    else $error("Select asserted outside an AT cycle.");
  a_pin_direction: assert property (
    $stable(pin_direction)
    |=> general_pins_oe[3:1] == $past(pin_direction[3:1]))
    else $error("Pin enable differs from direction.");
  a_grant_pin: assert property (
    !lbm_on && $stable(lbm_on)
    |=> dma_ack_pin_n == $past(dma_ack_channel_two_n))
    else $error("DMA ack not passed through.");
endmodule : pcs_top

//--- pio_chip_select_resume_ctrl_bench.sv
// Self-checking bench for the chip select, pin and resume block.
`timescale 1ns/10ps
`include "pcs_consts.svh"
module pio_chip_select_resume_ctrl_bench
  import pcs_pkg::*;
;
  typedef struct packed {
    logic [3:0]  f;
    logic [23:0] a;
    logic [3:0]  e;
  } pcs_row_s;
  logic          core_clk, sys_rst, suspend_active, s_axi_bready;
  logic [11:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]   s_axi_wdata, s_axi_rdata, rd_val;
  logic [3:0]    s_axi_wstrb, cs_ma_lines, power_latch_lines_low;
  logic [1:0]    s_axi_bresp, s_axi_rresp, rd_resp;
  logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic          s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic          s_axi_rready, at_cycle_strobe_n, peripheral_resume_reset_n;
  logic [3:0]    general_pins_in, general_pins_out, general_pins_oe;
  logic [3:0]    pins_pull_low;
  logic          secondary_reset_out_n, clock_run, cpu_full_speed_flag;
  logic          stop_grant_ack, zero_wait_active, last_clk;
  logic          dma_ack_channel_two_n, dma_ack_pin_n;
  pcs_at_cycle_s at_cycle;
  int            n_mismatch, tests_run, k, j, cnt;
  logic [7:0]    cs_base [4] = '{8'h4a, 8'h4c, 8'hba, 8'hbc};
  logic [7:0]    reg_idx [8] = '{8'h4a, 8'h4b, 8'h57, 8'h66, 8'ha0, 8'hb3,
                                 8'hbf, 8'h68};
  logic [7:0]    rec_w [5] = '{8'h00, 8'h05, 8'h0a, 8'h0f, 8'h03};
  int            rec_n [5] = '{20, 40, 60, 300, 100};
  // ROM rows stay above 1 MB.
  pcs_row_s      rows [12] = '{'{4'h3, 24'h000221, 4'hb},
    '{4'h2, 24'h000223, 4'h7}, '{4'h3, 24'h000225, 4'he},
    '{4'h3, 24'h000227, 4'hd}, '{4'h3, 24'h000220, 4'hf},
    '{4'h3, 24'h000621, 4'hf}, '{4'h7, 24'h000621, 4'hb},
    '{4'h1, 24'h000221, 4'hf}, '{4'h9, 24'h884000, 4'hb},
    '{4'h8, 24'h88c000, 4'h7}, '{4'h9, 24'h894000, 4'he},
    '{4'h9, 24'h89c000, 4'hd}};
  // Short recovery counts keep the run brief; 30 us stays at 300 cycles.
  pcs_top #(.REC_8MS_CYC(20), .REC_32MS_CYC(40), .REC_128MS_CYC(60),
    .REC_1S_CYC(100)) dut (.*);
  pcs_far_side far (.*);
  // Free-running 10 MHz clock.
  always #50 core_clk = ~core_clk;
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic conclude;
    $display("mismatches %0d compares %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_span(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask : chk_span
  // Each channel is released at the edge that takes it; a hang ends the run.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {24'ha5a5a5, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      k++;
    end
    while (s_axi_bvalid !== 1'b1 && k < 100);
    s_axi_bready <= 1'b0;
    rd_resp = s_axi_bresp;
    if (k >= 100) n_mismatch++;
    if (k >= 100) conclude();
  endtask : wr
  task automatic rd(input logic [7:0] idx);
    @(posedge core_clk);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      k++;
    end
    while (s_axi_rvalid !== 1'b1 && k < 100);
    s_axi_rready <= 1'b0;
    rd_val = s_axi_rdata;
    rd_resp = s_axi_rresp;
    if (k >= 100) n_mismatch++;
    if (k >= 100) conclude();
  endtask : rd
  // One AT cycle: the select shows while the strobe is low, then clears.
  task automatic cyc(input pcs_at_cycle_s c, input logic [3:0] exp);
    far.start(c);
    tick(2);
    chk(cs_ma_lines, exp);
    chk(zero_wait_active, 1'b1);
    far.stop();
    tick(2);
    chk(cs_ma_lines, 4'hf);
    chk(zero_wait_active, 1'b0);
  endtask : cyc
  initial
  begin
    {core_clk, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, suspend_active, pins_pull_low} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {sys_rst, cpu_full_speed_flag, dma_ack_channel_two_n} = '1;
    s_axi_wstrb = 4'hf;
    tick(10);
    sys_rst <= 1'b0;
    tick(3);
    chk({cs_ma_lines, power_latch_lines_low, general_pins_oe}, 12'hf00);
    chk({clock_run, dma_ack_pin_n, peripheral_resume_reset_n,
      secondary_reset_out_n}, 4'hf);
    foreach (reg_idx[i])
    begin
      rd(reg_idx[i]);
      chk(rd_val, 32'h0);
    end
    wr(`IDX_CS0_BASE, 8'h5a);
    s_axi_wstrb <= 4'h0;
    wr(`IDX_CS0_BASE, 8'h33);
    s_axi_wstrb <= 4'hf;
    rd(`IDX_CS0_BASE);
    chk({rd_resp, rd_val}, 34'h00000005a);
    rd(8'h00);
    chk({rd_resp, rd_val}, 34'h200000000);
    wr(8'h00, 8'hff);
    chk(rd_resp, 2'h2);
    // Four selects, each two I/O addresses above the last.
    foreach (cs_base[i])
    begin
      wr(cs_base[i], 8'h10 + 8'(i));
      wr(cs_base[i] + 8'h01, 8'he0);
    end
    wr(`IDX_CS_GRAN, 8'hf0);
    wr(`IDX_PIN_FUNC, 8'h0e);
    wr(`IDX_PIN_DIR, 8'h04);
    pins_pull_low <= 4'ha;
    for (j = 0; j < 12; j++)
    begin
      wr(`IDX_CS_TYPE, rows[j].f[3] ? 8'h0f : 8'h00);
      wr(`IDX_CS_HIGH, rows[j].f[2] ? 8'h80 : 8'h00);
      cyc('{rows[j].a, rows[j].f[1], rows[j].f[0], ~rows[j].f[0]},
        rows[j].e);
    end
    chk({stop_grant_ack, general_pins_oe[2], general_pins_out[2]},
      3'h7);
    wr(`IDX_CS0_CTRL, 8'hc0);
    wr(`IDX_CS_TYPE, 8'h00);
    cyc('{24'h221, 1'b1, 1'b1, 1'b0}, 4'hf);
    cyc('{24'h221, 1'b1, 1'b0, 1'b1}, 4'hb);
    cpu_full_speed_flag <= 1'b0;
    wr(`IDX_PIN_FUNC, 8'h00);
    wr(`IDX_PIN_DIR, 8'h03);
    pins_pull_low <= 4'h0;
    wr(`IDX_PIN_DATA, 8'hf5);
    tick(5);
    chk({stop_grant_ack, general_pins_oe, general_pins_out[1:0]},
      7'h0d);
    rd(`IDX_PIN_DATA);
    chk(rd_val[3:0], 4'hd);
    wr(`IDX_PIN_DATA, 8'h1a);
    tick(2);
    chk(general_pins_out[1:0], 2'h0);
    wr(`IDX_PIN_DIR, 8'h00);
    pins_pull_low <= 4'h1;
    wr(`IDX_FEATURE, 8'h20);
    tick(5);
    chk({dma_ack_pin_n, general_pins_oe[0]}, 2'h0);
    wr(`IDX_FEATURE, 8'h00);
    tick(2);
    chk(dma_ack_pin_n, 1'b1);
    dma_ack_channel_two_n <= 1'b0;
    tick(2);
    chk(dma_ack_pin_n, 1'b0);
    dma_ack_channel_two_n <= 1'b1;
    wr(`IDX_LATCH, 8'h35);
    tick(2);
    chk(power_latch_lines_low, 4'h1);
    wr(`IDX_LATCH, 8'h8f);
    tick(2);
    chk(power_latch_lines_low, 4'h9);
    // Every recovery code, then the one-second override.
    for (j = 0; j < 5; j++)
    begin
      wr(`IDX_RECOVERY, rec_w[j]);
      wr(`IDX_OVERRIDE, (j == 4) ? 8'h01 : 8'h00);
      suspend_active <= 1'b1;
      tick(4);
      chk(power_latch_lines_low,
        4'h9 ^ {2'b00, rec_w[j][1:0]});
      chk(clock_run, 1'b0);
      suspend_active <= 1'b0;
      tick(3);
      chk({power_latch_lines_low, peripheral_resume_reset_n,
        secondary_reset_out_n}, 6'h24);
      cnt = 3;
      while (peripheral_resume_reset_n !== 1'b1 && cnt < 2000)
      begin
        last_clk = clock_run;
        tick(1);
        cnt++;
      end
      chk_span(cnt, rec_n[j] + 1, rec_n[j] + 5);
      chk(last_clk, 1'b1);
    end
    // Reset in mid-recovery must release the resume resets at once.
    suspend_active <= 1'b1;
    tick(3);
    suspend_active <= 1'b0;
    tick(5);
    sys_rst <= 1'b1;
    tick(2);
    sys_rst <= 1'b0;
    tick(2);
    chk({power_latch_lines_low, peripheral_resume_reset_n,
      secondary_reset_out_n, cs_ma_lines}, 10'h03f);
    rd(`IDX_OVERRIDE);
    chk(rd_val, 32'h0);
    conclude();
  end
endmodule : pio_chip_select_resume_ctrl_bench
